// ---- rtl/pio_address_translator.sv ----
// Node hub routing plus bridge address translation for programmed I/O
// Assumes requests hold until accepted and one bus transaction is outstanding
//
// Notes on behaviour
// - Bridge issues programmed accesses as single address cycles only, never dual.
// - Every bus address driven for a programmed access is 32 bits wide.
// - Space flag set gives a memory transaction; clear gives an I/O transaction.
// - Address bits 31 to 20 are replaced with the 12-bit offset field.
// - Bits 27 to 20 select the attribute register; all bits above the low 20 are stripped.
// - Hub compares node-ID bits 48 to 38 with its own identity.
// - Matching node ID: request goes over the local link to the bridge.
// - Non-matching node ID: request goes across the network to the remote hub.
// - Bridge places the translated address on the bus as transaction address.
// - Expansion ROM base is left alone; no ROM code is run.
// - Interrupt-line configuration value is ignored by the platform.
`timescale 1ns/100ps
module pio_address_translator
   import pio_xlate_pkg::*;
#(
   parameter int NUM_ATTR = N_ATTR
) (
   // Clock and reset
   input  wire logic                  clock_i,
   input  wire logic                  rst_i,
   // Node identity and attribute programming
   input  wire logic [NODE_ID_W-1:0]  own_node_id_i,
   input  wire logic                  attr_we_i,
   input  wire logic [SEL_W-1:0]      attr_idx_i,
   input  wire logic [ATTR_W-1:0]     attr_wdata_i,
   // CPU request side
   input  wire logic                  req_valid_i,
   input  wire pio_req_t              req_i,
   output logic                       req_ready_o,
   output logic                       rsp_valid_o,
   output logic [DATA_W-1:0]          rsp_data_o,
   // Network side toward remote hub
   output logic                       net_valid_o,
   output pio_req_t                   net_req_o,
   input  wire logic                  net_ready_i,
   // Bus side toward targets
   output logic                       bus_valid_o,
   output bus_req_t                   bus_req_o,
   output logic                       bus_dac_o,
   input  wire logic                  bus_done_i,
   input  wire logic [DATA_W-1:0]     bus_rdata_i
);

   typedef enum logic [1:0] {IDLE, NET, BUS} state_t;

   state_t                  state;
   state_t                  next_state;
   pio_req_t                net_req;
   pio_req_t                next_net_req;
   bus_req_t                bus_req;
   bus_req_t                next_bus_req;
   logic                    rsp_valid;
   logic                    next_rsp_valid;
   logic [DATA_W-1:0]       rsp_data;
   logic [DATA_W-1:0]       next_rsp_data;
   logic [ATTR_W-1:0]       attr_mem [NUM_ATTR];
   logic [ATTR_W-1:0]       next_attr_mem [NUM_ATTR];
   logic [ATTR_W-1:0]       sel_attr;
   logic                    is_local;

   function automatic logic [BUS_ADDR_W-1:0] xlate(input logic [CPU_ADDR_W-1:0] a,
                                                   input logic [ATTR_W-1:0] at);
      // Strip select bits, prepend offset; result is 32 bits
      xlate = {at[OFF_W-1:0], a[KEEP_W-1:0]};
   endfunction

   assign is_local = (req_i.addr[NODE_ID_MSB:NODE_ID_LSB] == own_node_id_i);
   assign sel_attr = attr_mem[req_i.addr[SEL_LSB+SEL_W-1:SEL_LSB]];

   // Attribute registers
   always_comb begin
      for (int i = 0; i < NUM_ATTR; i++) begin
         next_attr_mem[i] = attr_mem[i];
      end
      if (attr_we_i) begin
         next_attr_mem[attr_idx_i] = attr_wdata_i;
      end
   end

   always_ff @(posedge clock_i) begin
      for (int i = 0; i < NUM_ATTR; i++) begin
         if (rst_i) begin
            attr_mem[i] <= ATTR_RESET;
         end else begin
            attr_mem[i] <= next_attr_mem[i];
         end
      end
   end

   always_comb begin
      next_state     = state;
      next_net_req   = net_req;
      next_bus_req   = bus_req;
      next_rsp_valid = 1'b0;
      next_rsp_data  = rsp_data;
      unique case (state)
         IDLE: begin
            if (req_valid_i) begin
               if (is_local) begin
                  // Only memory or I/O cycles, never configuration
                  next_state             = BUS;
                  next_bus_req.mem_space = sel_attr[ATTR_SPACE_POS];
                  next_bus_req.write     = req_i.write;
                  next_bus_req.addr      = xlate(req_i.addr, sel_attr);
                  next_bus_req.data      = req_i.data;
               end else begin
                  next_state   = NET;
                  next_net_req = req_i;
               end
            end
         end
         NET: begin
            if (net_ready_i) begin
               next_state = IDLE;
            end
         end
         BUS: begin
            if (bus_done_i) begin
               next_state     = IDLE;
               next_rsp_valid = 1'b1;
               next_rsp_data  = bus_req.write ? rsp_data : bus_rdata_i;
            end
         end
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         state     <= IDLE;
         net_req   <= '0;
         bus_req   <= '0;
         rsp_valid <= 1'b0;
         rsp_data  <= '0;
      end else begin
         state     <= next_state;
         net_req   <= next_net_req;
         bus_req   <= next_bus_req;
         rsp_valid <= next_rsp_valid;
         rsp_data  <= next_rsp_data;
      end
   end

   assign req_ready_o = (state == IDLE);
   assign net_valid_o = (state == NET);
   assign net_req_o   = net_req;
   assign bus_valid_o = (state == BUS);
   assign bus_req_o   = bus_req;
   assign bus_dac_o   = 1'b0;
   assign rsp_valid_o = rsp_valid;
   assign rsp_data_o  = rsp_data;

   // Checks on routing, translation and handshakes

   AST_NO_DAC: assert property (
      @(posedge clock_i) disable iff (rst_i)
      bus_valid_o |-> !bus_dac_o
   ) else $error("dual address cycle driven");

   AST_ADDR_XLATE: assert property (
      @(posedge clock_i) disable iff (rst_i)
      (state == IDLE && req_valid_i && is_local) |=>
      bus_valid_o && bus_req_o.addr == {$past(sel_attr[OFF_W-1:0]), $past(req_i.addr[KEEP_W-1:0])}
   ) else $error("bus address not translated");

   AST_LOW_KEEP: assert property (
      @(posedge clock_i) disable iff (rst_i)
      (state == IDLE && req_valid_i && is_local) |=>
      bus_req_o.addr[KEEP_W-1:0] == $past(req_i.addr[KEEP_W-1:0])
   ) else $error("low address bits changed");

   AST_SPACE: assert property (
      @(posedge clock_i) disable iff (rst_i)
      (state == IDLE && req_valid_i && is_local) |=>
      bus_req_o.mem_space == $past(sel_attr[ATTR_SPACE_POS])
   ) else $error("wrong address space");

   AST_LOCAL: assert property (
      @(posedge clock_i) disable iff (rst_i)
      (state == IDLE && req_valid_i && is_local) |=> bus_valid_o && !net_valid_o
   ) else $error("local request not sent to bridge");

   AST_REMOTE: assert property (
      @(posedge clock_i) disable iff (rst_i)
      (state == IDLE && req_valid_i && !is_local) |=>
      net_valid_o && !bus_valid_o && net_req_o == $past(req_i)
   ) else $error("remote request not forwarded");

   AST_NODE_CMP: assert property (
      @(posedge clock_i) disable iff (rst_i)
      (state == IDLE && req_valid_i &&
       req_i.addr[NODE_ID_MSB:NODE_ID_LSB] != own_node_id_i) |=> !bus_valid_o
   ) else $error("foreign node reached bus");

   AST_RDATA: assert property (
      @(posedge clock_i) disable iff (rst_i)
      (bus_valid_o && bus_done_i && !bus_req_o.write) |=>
      rsp_valid_o && rsp_data_o == $past(bus_rdata_i)
   ) else $error("read data altered");

   AST_WDATA: assert property (
      @(posedge clock_i) disable iff (rst_i)
      (state == IDLE && req_valid_i && is_local) |=> bus_req_o.data == $past(req_i.data)
   ) else $error("write data altered");

   AST_BUS_HOLD: assert property (
      @(posedge clock_i) disable iff (rst_i)
      (bus_valid_o && !bus_done_i) |=> bus_valid_o && $stable(bus_req_o)
   ) else $error("bus request changed before done");

   AST_NET_HOLD: assert property (
      @(posedge clock_i) disable iff (rst_i)
      (net_valid_o && !net_ready_i) |=> net_valid_o && $stable(net_req_o)
   ) else $error("network request changed before accepted");

   AST_RSP_PULSE: assert property (
      @(posedge clock_i) disable iff (rst_i)
      rsp_valid_o |=> !rsp_valid_o
   ) else $error("response longer than one cycle");

   AST_RSP_CAUSE: assert property (
      @(posedge clock_i) disable iff (rst_i)
      rsp_valid_o |-> $past(bus_valid_o && bus_done_i)
   ) else $error("response without bus completion");

   AST_ONE_PATH: assert property (
      @(posedge clock_i) disable iff (rst_i)
      !(bus_valid_o && net_valid_o)
   ) else $error("request on both paths");

   AST_BUS_RELEASE: assert property (
      @(posedge clock_i) disable iff (rst_i)
      (bus_valid_o && bus_done_i) |=> !bus_valid_o && req_ready_o
   ) else $error("bus request not released");

   AST_NET_RELEASE: assert property (
      @(posedge clock_i) disable iff (rst_i)
      (net_valid_o && net_ready_i) |=> !net_valid_o && req_ready_o
   ) else $error("network request not released");

   AST_ATTR_WRITE: assert property (
      @(posedge clock_i) disable iff (rst_i)
      attr_we_i |=> attr_mem[$past(attr_idx_i)] == $past(attr_wdata_i)
   ) else $error("attribute entry not written");

   AST_WRITE_RSP: assert property (
      @(posedge clock_i) disable iff (rst_i)
      (bus_valid_o && bus_done_i && bus_req_o.write) |=> rsp_valid_o && $stable(rsp_data_o)
   ) else $error("write completion response wrong");

   AST_IDLE_QUIET: assert property (
      @(posedge clock_i) disable iff (rst_i)
      req_ready_o |-> !bus_valid_o && !net_valid_o
   ) else $error("request pending while ready");

   COV_LOCAL_READ: cover property (
      @(posedge clock_i) disable iff (rst_i)
      bus_valid_o && bus_done_i && !bus_req_o.write
   );

   COV_LOCAL_WRITE: cover property (
      @(posedge clock_i) disable iff (rst_i)
      bus_valid_o && bus_done_i && bus_req_o.write
   );

   COV_REMOTE: cover property (
      @(posedge clock_i) disable iff (rst_i)
      net_valid_o && net_ready_i
   );

   COV_IO_SPACE: cover property (
      @(posedge clock_i) disable iff (rst_i)
      bus_valid_o && !bus_req_o.mem_space
   );

   COV_MEM_SPACE: cover property (
      @(posedge clock_i) disable iff (rst_i)
      bus_valid_o && bus_req_o.mem_space
   );
endmodule

// ---- rtl/pio_xlate_pkg.sv ----
// Package for the programmed-I/O address translator
// Assumes a single 200 MHz clock and synchronous active-high reset
package pio_xlate_pkg;
   localparam int CPU_ADDR_W    = 64;
   localparam int BUS_ADDR_W    = 32;
   localparam int DATA_W        = 32;
   localparam int NODE_ID_W     = 11;
   localparam int NODE_ID_LSB   = 38;
   localparam int NODE_ID_MSB   = 48;
   localparam int KEEP_W        = 20;
   localparam int SEL_LSB       = 20;
   localparam int SEL_W         = 8;
   localparam int OFF_W         = 12;
   localparam int ATTR_W        = 16;
   localparam int ATTR_SPACE_POS = 12;
   localparam int N_ATTR        = 256;
   localparam logic [ATTR_W-1:0] ATTR_RESET = 16'h0000;
   localparam int ATTR_MEM_SPACE = 1;

   typedef struct packed {
      logic                  write;
      logic [CPU_ADDR_W-1:0] addr;
      logic [DATA_W-1:0]     data;
   } pio_req_t;

   typedef struct packed {
      logic                  mem_space;
      logic                  write;
      logic [BUS_ADDR_W-1:0] addr;
      logic [DATA_W-1:0]     data;
   } bus_req_t;
endpackage

// ---- verif/far_side_model.sv ----
// Far-side model: bus target and network port
// Assumes one clock; answers change on the rising edge
`timescale 1ns/100ps
module far_side_model
   import pio_xlate_pkg::*;
(
   // Clock and reset
   input  wire logic             clock_i,
   input  wire logic             rst_i,
   // Requests and answer delay
   input  wire logic             bus_valid_i,
   input  wire bus_req_t         bus_req_i,
   input  wire logic             net_valid_i,
   input  wire logic [3:0]       delay_i,
   // Answers
   output logic                  bus_done_o,
   output logic [DATA_W-1:0]     bus_rdata_o,
   output logic                  net_ready_o
);
   // Configuration space of the target is not reached by this block
   logic [3:0] cnt;
   always_ff @(posedge clock_i) begin
      bus_done_o <= 1'b0;
      bus_rdata_o <= ~bus_rdata_o;
      net_ready_o <= net_valid_i && !net_ready_o && !rst_i;
      if (rst_i) begin
         cnt <= 4'h0;
      end else if (bus_valid_i && !bus_done_o) begin
         cnt <= cnt + 4'h1;
         if (cnt >= delay_i) begin
            // Target claims and completes after the chosen delay
            cnt <= 4'h0;
            bus_done_o <= 1'b1;
            bus_rdata_o <= bus_req_i.addr ^ 32'h5A5A_A5A5;
         end
      end
   end
endmodule

// ---- verif/tb_top.sv ----
// Testbench for the programmed-I/O address translator
// Assumes the far-side model answers bus and network requests
`timescale 1ns/100ps
module tb_top
   import pio_xlate_pkg::*;
;
   logic clock_i, rst_i, attr_we_i, req_valid_i, req_ready, rsp_valid, net_valid, net_ready;
   logic bus_valid, bus_dac, bus_done;
   logic [NODE_ID_W-1:0] own_node_id_i;
   logic [SEL_W-1:0]     attr_idx_i;
   logic [ATTR_W-1:0]    attr_wdata_i;
   logic [DATA_W-1:0]    rsp_data, bus_rdata;
   logic [3:0]           delay;
   pio_req_t             req_i, net_req;
   bus_req_t             bus_req;
   logic [ATTR_W-1:0]    shadow [N_ATTR];
   logic [31:0]          seed;
   int                   err_count, n_compared;
   pio_address_translator u_dut (.clock_i(clock_i), .rst_i(rst_i), .own_node_id_i(own_node_id_i),
      .attr_we_i(attr_we_i), .attr_idx_i(attr_idx_i), .attr_wdata_i(attr_wdata_i),
      .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready), .rsp_valid_o(rsp_valid),
      .rsp_data_o(rsp_data), .net_valid_o(net_valid), .net_req_o(net_req),
      .net_ready_i(net_ready), .bus_valid_o(bus_valid), .bus_req_o(bus_req),
      .bus_dac_o(bus_dac), .bus_done_i(bus_done), .bus_rdata_i(bus_rdata));
   far_side_model u_far (.clock_i(clock_i), .rst_i(rst_i), .bus_valid_i(bus_valid),
      .bus_req_i(bus_req), .net_valid_i(net_valid), .delay_i(delay), .bus_done_o(bus_done),
      .bus_rdata_o(bus_rdata), .net_ready_o(net_ready));
   initial begin
      clock_i = 1'b0;
      forever #2.5 clock_i = ~clock_i;
   end
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic wrap_up();
      $display("Compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk_val(string what, logic [96:0] exp, logic [96:0] got);
      n_compared++;
      if (got !== exp) begin
         $display("FAIL %s expected %h seen %h", what, exp, got);
         err_count++;
      end
   endtask
   task automatic tick();
      @(posedge clock_i);
      #1;
   endtask
   task automatic wait_hi(ref logic s, input string what);
      for (int i = 0; i < 40 && s !== 1'b1; i++) tick();
      chk_val(what, 97'h1, {96'h0, s});
      if (s !== 1'b1) wrap_up();
   endtask
   task automatic set_attr(logic [7:0] idx, logic [15:0] d);
      attr_we_i = 1'b1;
      attr_idx_i = idx;
      attr_wdata_i = d;
      tick();
      attr_we_i = 1'b0;
      shadow[idx] = d;
   endtask
   task automatic do_req(logic w, logic [63:0] a, logic [31:0] d);
      logic [15:0] e;
      e = shadow[a[27:20]];
      req_i = '{w, a, d};
      req_valid_i = 1'b1;
      wait_hi(req_ready, "ready");
      tick();
      req_valid_i = 1'b0;
      if (a[48:38] == own_node_id_i) begin
         wait_hi(bus_valid, "bus valid");
         chk_val("net valid", 97'h0, {96'h0, net_valid});
         chk_val("bus addr", {e[11:0], a[19:0]}, bus_req.addr);
         chk_val("space", e[12], bus_req.mem_space);
         chk_val("dac", 97'h0, {96'h0, bus_dac});
         chk_val("wdata", {w, d}, {bus_req.write, bus_req.data});
         wait_hi(rsp_valid, "rsp valid");
         if (!w) chk_val("rdata", {e[11:0], a[19:0]} ^ 32'h5A5A_A5A5, rsp_data);
      end else begin
         wait_hi(net_valid, "net valid");
         chk_val("bus valid", 97'h0, {96'h0, bus_valid});
         chk_val("net req", req_i, net_req);
      end
      wait_hi(req_ready, "idle");
   endtask
   initial begin
      logic [31:0] r;
      logic [31:0] r2;
      logic [63:0] a;
      {attr_we_i, attr_idx_i, attr_wdata_i, req_valid_i, req_i, own_node_id_i} = '0;
      err_count = 0;
      n_compared = 0;
      rst_i = 1'b1;
      delay = 4'h0;
      seed = 32'hCC8D;
      foreach (shadow[i]) shadow[i] = ATTR_RESET;
      repeat (5) @(posedge clock_i);
      #1 rst_i = 1'b0;
      chk_val("reset valids", 97'h0, {95'h0, bus_valid, net_valid});
      do_req(1'b0, 64'h0000_0000_0123_4567, 32'h0);
      set_attr(8'hE4, 16'h11FF);
      do_req(1'b0, 64'hC000_0008_0E4F_0000, 32'h0);
      do_req(1'b1, 64'hC000_0008_0E4F_0010, 32'hFFFF_0000);
      do_req(1'b1, 64'h0000_0040_0E4F_0000, 32'h1234_5678);
      rst_i = 1'b1;
      tick();
      rst_i = 1'b0;
      foreach (shadow[i]) shadow[i] = ATTR_RESET;
      do_req(1'b0, 64'h0000_0000_0E4F_0000, 32'h0);
      for (int k = 0; k < 60; k++) begin
         r = rnd();
         delay = r[3:0];
         own_node_id_i = r[15:5];
         r2 = rnd();
         set_attr(r[23:16], r2[15:0]);
         a = {rnd(), rnd()};
         if (r[4]) a[48:38] = own_node_id_i;
         if (r[24]) a[27:20] = r[23:16];
         do_req(r[25], a, rnd());
      end
      wrap_up();
   end
endmodule
